// >>> src/zbi_timing.sv
// zone decode and wait/hold/idle cycle sequencer for the core bus
`timescale 1ns/1ps
// Summary of operation
// - wait field adds zero to seven internal wait cycles per zone access
// - hold field adds zero to three hold cycles
// - fast read set makes flash wait and hold fields ignored
// - bus width bit selects 8 or 16 bit bus, resets to 16
// - post idle adds one idle cycle when next cycle changes zone
// - preliminary idle adds one idle cycle before entering the flash zone from another zone
// - fast read gives one-clock reads, otherwise two clocks or more
// - 0000-BFFF is flash zone, timed by flash register and early write
// - fast flash read adds no wait and no hold
// - normal flash read adds one plus wait field, hold field holds
// - fast-mode flash write adds one plus early write, no hold
// - normal flash write adds wait plus one or two, hold field holds
// - RAM E000-E7FF has no wait and no hold
// - EEPROM reads add one wait unless fast EEPROM set, never hold
// - core registers and peripherals F280-FFFF outside the port page add one wait, no hold
// - port range FB00-FBFF timed by the I/O zone register
// - early write bit selects late or early write, resets early
// - normal read two clocks, fast read one, late write two
// - waits follow the address, holds extend the end of cycle
module zbi_timing (
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   input  wire logic        ce,
   input  wire logic        core_req,
   input  wire logic        core_wr,
   input  wire logic [15:0] core_addr,
   input  wire logic [15:0] core_wdata,
   output logic             core_done,
   output logic      [15:0] core_rdata,
   input  wire logic        fast_eeprom_access,
   input  wire logic [15:0] mem_rdata,
   output logic      [15:0] mem_addr,
   output logic      [15:0] mem_wdata,
   output logic             mem_wr,
   output logic      [2:0]  mem_zone,
   output logic             mem_active,
   output logic             mem_hold,
   output logic             flash_bus_16,
   output logic             io_bus_16
);
   // -----------------------------------------------------------------
   // reset release
   // -----------------------------------------------------------------
   logic rst_m_r;
   logic rst_s_r;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rst_m_r <= 1'b0;
         rst_s_r <= 1'b0;
      end else begin
         rst_m_r <= 1'b1;
         rst_s_r <= rst_m_r;
      end
   end
   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   typedef struct packed {
      zbi_pkg::zbi_state_type st;
      logic [1:0]             cnt_gap;
      logic [3:0]             cnt;
      logic [3:0]             wait_ld;
      logic [1:0]             hold_ld;
      zbi_pkg::zbi_zone_type  zone;
      zbi_pkg::zbi_zone_type  last_zone;
      logic                   last_valid;
      logic                   last_post;
      logic [15:0]            addr;
      logic [15:0]            wdata;
      logic                   wr;
      logic [15:0]            rdata;
      logic                   done;
   } zbi_seq_type;
   zbi_seq_type s_r;
   zbi_seq_type s_nxt;
   logic [15:0] io_cfg;
   logic [15:0] fl_cfg;
   logic [15:0] bu_cfg;
   logic        finish;
   logic        accept;
   // -----------------------------------------------------------------
   // configuration registers
   // -----------------------------------------------------------------
   logic we_io;
   logic we_fl;
   logic we_bu;
   always_comb begin
      we_io = 1'b0;
      we_fl = 1'b0;
      we_bu = 1'b0;
      if (finish && s_r.wr) begin
         if (s_r.addr == zbi_pkg::ADDR_IO_ZONE_CFG) begin
            we_io = 1'b1;
         end else if (s_r.addr == zbi_pkg::ADDR_FLASH_CFG) begin
            we_fl = 1'b1;
         end else if (s_r.addr == zbi_pkg::ADDR_BUS_UNIT_CFG) begin
            we_bu = 1'b1;
         end
      end
   end
   zbi_cfg_reg #(.RST(zbi_pkg::RST_IO_ZONE_CFG), .MSK(zbi_pkg::MSK_IO_ZONE_CFG)) u_io (
      .clk_sys (clk_sys),
      .rst_n   (rst_s_r),
      .ce      (ce),
      .we      (we_io),
      .wdata   (s_r.wdata),
      .q       (io_cfg)
   );
   zbi_cfg_reg #(.RST(zbi_pkg::RST_FLASH_CFG), .MSK(zbi_pkg::MSK_FLASH_CFG)) u_fl (
      .clk_sys (clk_sys),
      .rst_n   (rst_s_r),
      .ce      (ce),
      .we      (we_fl),
      .wdata   (s_r.wdata),
      .q       (fl_cfg)
   );
   zbi_cfg_reg #(.RST(zbi_pkg::RST_BUS_UNIT_CFG), .MSK(zbi_pkg::MSK_BUS_UNIT_CFG)) u_bu (
      .clk_sys (clk_sys),
      .rst_n   (rst_s_r),
      .ce      (ce),
      .we      (we_bu),
      .wdata   (s_r.wdata),
      .q       (bu_cfg)
   );
   // -----------------------------------------------------------------
   // field views
   // -----------------------------------------------------------------
   logic       fast_rd;
   logic       early_wr;
   logic [3:0] fl_wait;
   logic [1:0] fl_hold;
   logic [3:0] io_wait;
   logic [1:0] io_hold;
   assign fast_rd  = fl_cfg[zbi_pkg::FAST_RD_BIT];
   assign early_wr = bu_cfg[zbi_pkg::EARLY_WR_BIT];
   assign fl_wait  = {1'b0, fl_cfg[zbi_pkg::WAIT_LSB +: 3]};
   assign fl_hold  = fl_cfg[zbi_pkg::HOLD_LSB +: 2];
   assign io_wait  = {1'b0, io_cfg[zbi_pkg::WAIT_LSB +: 3]};
   assign io_hold  = io_cfg[zbi_pkg::HOLD_LSB +: 2];
   assign flash_bus_16 = fl_cfg[zbi_pkg::WIDTH_BIT];
   assign io_bus_16    = io_cfg[zbi_pkg::WIDTH_BIT];
   // -----------------------------------------------------------------
   // zone decode and cycle budget of the incoming request
   // -----------------------------------------------------------------
   zbi_pkg::zbi_zone_type zn;
   logic [3:0] base;
   logic [3:0] wt;
   logic [1:0] hd;
   logic [1:0] gap;
   logic       pre;
   always_comb begin
      if (core_addr <= zbi_pkg::FLASH_TOP) begin
         zn = zbi_pkg::ZN_FLASH;
      end else if (core_addr >= zbi_pkg::RAM_LO && core_addr <= zbi_pkg::RAM_HI) begin
         zn = zbi_pkg::ZN_RAM;
      end else if (core_addr >= zbi_pkg::EE_LO && core_addr <= zbi_pkg::EE_HI) begin
         zn = zbi_pkg::ZN_EE;
      end else if (core_addr[15:8] == zbi_pkg::IO_PAGE) begin
         zn = zbi_pkg::ZN_IO;
      end else if (core_addr >= zbi_pkg::CORE_LO) begin
         zn = zbi_pkg::ZN_CORE;
      end else begin
         zn = zbi_pkg::ZN_NONE;
      end
   end
   always_comb begin
      base = zbi_pkg::BASE_NORMAL;
      wt   = 4'h0;
      hd   = 2'h0;
      case (zn)
         zbi_pkg::ZN_FLASH: begin
            if (fast_rd) begin
               if (core_wr) begin
                  wt = zbi_pkg::WAIT_ONE + {3'h0, early_wr};
               end else begin
                  base = zbi_pkg::BASE_FAST;
               end
            end else if (core_wr) begin
               wt = zbi_pkg::WAIT_ONE + {3'h0, early_wr} + fl_wait;
               hd = fl_hold;
            end else begin
               wt = zbi_pkg::WAIT_ONE + fl_wait;
               hd = fl_hold;
            end
         end
         zbi_pkg::ZN_RAM: begin
            wt = 4'h0;
         end
         zbi_pkg::ZN_EE: begin
            wt = {3'h0, ~fast_eeprom_access};
         end
         zbi_pkg::ZN_IO: begin
            if (core_wr) begin
               wt = zbi_pkg::WAIT_ONE + {3'h0, early_wr} + io_wait;
            end else begin
               wt = zbi_pkg::WAIT_ONE + io_wait;
            end
            hd = io_hold;
         end
         default: begin
            wt = zbi_pkg::WAIT_ONE;
         end
      endcase
   end
   // one idle from the old zone's post bit and one from the new zone's pre bit
   assign pre = (zn == zbi_pkg::ZN_FLASH) && fl_cfg[zbi_pkg::PRE_IDLE_BIT];
   always_comb begin
      gap = 2'h0;
      if (s_r.last_valid && zn != s_r.last_zone) begin
         gap = {1'b0, s_r.last_post} + {1'b0, pre};
      end
   end
   // -----------------------------------------------------------------
   // sequencer
   // -----------------------------------------------------------------
   // no new request in the done cycle: the core still holds the old one
   assign accept = (s_r.st == zbi_pkg::ST_IDLE) && core_req && !s_r.done;
   always_comb begin
      finish = 1'b0;
      s_nxt  = s_r;
      s_nxt.done = 1'b0;
      case (s_r.st)
         zbi_pkg::ST_IDLE: begin
            if (accept) begin
               s_nxt.addr    = core_addr;
               s_nxt.wdata   = core_wdata;
               s_nxt.wr      = core_wr;
               s_nxt.zone    = zn;
               s_nxt.wait_ld = base + wt - 4'h1;
               s_nxt.hold_ld = hd;
               if (gap != 2'h0) begin
                  s_nxt.st      = zbi_pkg::ST_GAP;
                  s_nxt.cnt_gap = gap - 2'h1;
               end else begin
                  s_nxt.st  = zbi_pkg::ST_WAIT;
                  s_nxt.cnt = base + wt - 4'h1;
               end
            end
         end
         zbi_pkg::ST_GAP: begin
            if (s_r.cnt_gap == 2'h0) begin
               s_nxt.st  = zbi_pkg::ST_WAIT;
               s_nxt.cnt = s_r.wait_ld;
            end else begin
               s_nxt.cnt_gap = s_r.cnt_gap - 2'h1;
            end
         end
         zbi_pkg::ST_WAIT: begin
            if (s_r.cnt != 4'h0) begin
               s_nxt.cnt = s_r.cnt - 4'h1;
            end else if (s_r.hold_ld != 2'h0) begin
               s_nxt.st  = zbi_pkg::ST_HOLD;
               s_nxt.cnt = {2'h0, s_r.hold_ld} - 4'h1;
            end else begin
               finish = 1'b1;
            end
         end
         zbi_pkg::ST_HOLD: begin
            if (s_r.cnt != 4'h0) begin
               s_nxt.cnt = s_r.cnt - 4'h1;
            end else begin
               finish = 1'b1;
            end
         end
         default: begin
            s_nxt.st = zbi_pkg::ST_IDLE;
         end
      endcase
      if (finish) begin
         s_nxt.st         = zbi_pkg::ST_IDLE;
         s_nxt.done       = 1'b1;
         s_nxt.last_zone  = s_r.zone;
         s_nxt.last_valid = 1'b1;
         s_nxt.last_post  = (s_r.zone == zbi_pkg::ZN_FLASH) ? fl_cfg[zbi_pkg::POST_IDLE_BIT] :
                            (s_r.zone == zbi_pkg::ZN_IO) ? io_cfg[zbi_pkg::POST_IDLE_BIT] : 1'b0;
         if (s_r.wr) begin
            s_nxt.rdata = s_r.rdata;
         end else if (s_r.addr == zbi_pkg::ADDR_IO_ZONE_CFG) begin
            s_nxt.rdata = io_cfg;
         end else if (s_r.addr == zbi_pkg::ADDR_FLASH_CFG) begin
            s_nxt.rdata = fl_cfg;
         end else if (s_r.addr == zbi_pkg::ADDR_BUS_UNIT_CFG) begin
            s_nxt.rdata = bu_cfg;
         end else if (s_r.zone == zbi_pkg::ZN_NONE) begin
            s_nxt.rdata = 16'h0000;
         end else begin
            s_nxt.rdata = mem_rdata;
         end
      end
   end
   always_ff @(posedge clk_sys or negedge rst_s_r) begin
      if (!rst_s_r) begin
         s_r <= '0;
      end else if (ce) begin
         s_r <= s_nxt;
      end
   end
   // -----------------------------------------------------------------
   // outputs
   // -----------------------------------------------------------------
   assign core_done  = s_r.done;
   assign core_rdata = s_r.rdata;
   assign mem_addr   = s_r.addr;
   assign mem_wdata  = s_r.wdata;
   assign mem_wr     = s_r.wr;
   assign mem_zone   = s_r.zone;
   assign mem_active = (s_r.st == zbi_pkg::ST_WAIT) || (s_r.st == zbi_pkg::ST_HOLD);
   assign mem_hold   = (s_r.st == zbi_pkg::ST_HOLD);
   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   logic [4:0] lat;
   logic [4:0] exp_len;
   always_ff @(posedge clk_sys or negedge rst_s_r) begin
      if (!rst_s_r) begin
         lat     <= 5'h00;
         exp_len <= 5'h00;
      end else if (ce) begin
         if (accept) begin
            lat     <= 5'h01;
            exp_len <= {1'b0, base} + {1'b0, wt} + {3'h0, hd} + {3'h0, gap} + 5'h01;
         end else if (s_r.st != zbi_pkg::ST_IDLE || s_r.done) begin
            lat <= lat + 5'h01;
         end
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_s_r || !ce);
   a_latency_total: assert property (core_done |-> lat == exp_len)
      else $error("completion at wrong cycle count");
   a_done_single: assert property (core_done |=> !core_done)
      else $error("completion longer than one clock");
   a_fast_read: assert property (accept && zn == zbi_pkg::ZN_FLASH && fast_rd && !core_wr
      && gap == 2'h0 |-> ##2 core_done)
      else $error("fast flash read not one clock");
   a_ram_nowait: assert property (accept && zn == zbi_pkg::ZN_RAM && gap == 2'h0
      |-> !core_done ##1 !core_done ##1 !core_done ##1 core_done)
      else $error("ram access not two clocks");
   a_core_onewait: assert property (accept && zn == zbi_pkg::ZN_CORE && gap == 2'h0
      |-> ##4 core_done)
      else $error("core register access not one wait");
   a_hold_zone: assert property (mem_hold |-> (mem_zone == zbi_pkg::ZN_IO)
      || (mem_zone == zbi_pkg::ZN_FLASH && !fast_rd))
      else $error("hold cycle in zone without hold field");
   a_gap_idle: assert property (s_r.st == zbi_pkg::ST_GAP |-> !mem_active ##1 !core_done)
      else $error("idle cycle drives memory");
   a_pre_idle: assert property (accept && zn != s_r.last_zone && s_r.last_valid
      && pre |=> s_r.st == zbi_pkg::ST_GAP)
      else $error("no idle before new flash zone");
   a_zone_kept: assert property (core_done |-> s_r.last_zone == s_r.zone)
      else $error("last zone not recorded");
   a_cfg_write: assert property (we_fl |=> fl_cfg ==
      (($past(fl_cfg) & ~zbi_pkg::MSK_FLASH_CFG) | ($past(s_r.wdata) & zbi_pkg::MSK_FLASH_CFG)))
      else $error("flash zone register write lost");
   c_fast_read: cover property (accept && zn == zbi_pkg::ZN_FLASH && fast_rd && !core_wr);
   c_hold_seen: cover property ($rose(mem_hold));
   c_gap_seen: cover property (s_r.st == zbi_pkg::ST_GAP);
   c_io_write: cover property (accept && zn == zbi_pkg::ZN_IO && core_wr);
endmodule : zbi_timing

// >>> src/zbi_pkg.sv
// constants and types for the zone wait/hold bus timing block
package zbi_pkg;
   // -----------------------------------------------------------------
   // register addresses
   // -----------------------------------------------------------------
   localparam logic [15:0] ADDR_BUS_UNIT_CFG = 16'hF900;
   localparam logic [15:0] ADDR_IO_ZONE_CFG  = 16'hF902;
   localparam logic [15:0] ADDR_FLASH_CFG    = 16'hF904;
   // -----------------------------------------------------------------
   // reset values and writable masks
   // -----------------------------------------------------------------
   localparam logic [15:0] RST_IO_ZONE_CFG  = 16'h069F;
   localparam logic [15:0] RST_FLASH_CFG    = 16'h069F;
   localparam logic [15:0] RST_BUS_UNIT_CFG = 16'h0007;
   localparam logic [15:0] MSK_IO_ZONE_CFG  = 16'h029F;
   localparam logic [15:0] MSK_FLASH_CFG    = 16'h0EFF;
   localparam logic [15:0] MSK_BUS_UNIT_CFG = 16'h0007;
   // -----------------------------------------------------------------
   // field positions
   // -----------------------------------------------------------------
   localparam int WAIT_LSB      = 0;
   localparam int HOLD_LSB      = 3;
   localparam int WIDTH_BIT     = 7;
   localparam int POST_IDLE_BIT = 9;
   localparam int PRE_IDLE_BIT  = 10;
   localparam int FAST_RD_BIT   = 11;
   localparam int EARLY_WR_BIT  = 0;
   // -----------------------------------------------------------------
   // address zones
   // -----------------------------------------------------------------
   localparam logic [15:0] FLASH_TOP = 16'hBFFF;
   localparam logic [15:0] RAM_LO    = 16'hE000;
   localparam logic [15:0] RAM_HI    = 16'hE7FF;
   localparam logic [15:0] EE_LO     = 16'hF000;
   localparam logic [15:0] EE_HI     = 16'hF27F;
   localparam logic [7:0]  IO_PAGE   = 8'hFB;
   localparam logic [15:0] CORE_LO   = 16'hF000;
   // -----------------------------------------------------------------
   // basic cycle lengths in clocks
   // -----------------------------------------------------------------
   localparam logic [3:0] BASE_FAST   = 4'h1;
   localparam logic [3:0] BASE_NORMAL = 4'h2;
   localparam logic [3:0] WAIT_ONE    = 4'h1;
   typedef enum logic [2:0] {
      ZN_FLASH = 3'h0, ZN_RAM = 3'h1, ZN_EE = 3'h2,
      ZN_CORE  = 3'h3, ZN_IO  = 3'h4, ZN_NONE = 3'h5
   } zbi_zone_type;
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0, ST_GAP = 2'h1, ST_WAIT = 2'h3, ST_HOLD = 2'h2
   } zbi_state_type;
endpackage : zbi_pkg

// >>> src/zbi_cfg_reg.sv
// one masked configuration register written at bus-cycle completion
`timescale 1ns/1ps
module zbi_cfg_reg #(
   parameter logic [15:0] RST = 16'h0000,
   parameter logic [15:0] MSK = 16'hFFFF
) (
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   input  wire logic        ce,
   input  wire logic        we,
   input  wire logic [15:0] wdata,
   output logic      [15:0] q
);
   typedef struct packed {
      logic [15:0] val;
   } zbi_cfg_type;
   zbi_cfg_type s_r;
   zbi_cfg_type s_nxt;
   // reserved bits keep their reset value, so a read shows it unchanged
   always_comb begin
      s_nxt = s_r;
      if (we) begin
         s_nxt.val = (s_r.val & ~MSK) | (wdata & MSK);
      end
   end
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s_r.val <= RST;
      end else if (ce) begin
         s_r <= s_nxt;
      end
   end
   assign q = s_r.val;
endmodule : zbi_cfg_reg

// >>> tb/zbi_mem_model.sv
// far-side memory and peripheral model answering the zone timing block
`timescale 1ns/1ps
module zbi_mem_model (
   input  wire logic        clk_sys,
   input  wire logic [15:0] mem_addr,
   input  wire logic        mem_active,
   output logic      [15:0] mem_rdata
);
   logic [15:0] junk_r = 16'h0000;
   // -----------------------------------------------------------------
   // read data
   // -----------------------------------------------------------------
   // outside an access the bus moves every cycle so stale data never matches
   always @(posedge clk_sys) begin
      junk_r <= junk_r + 16'h3B1D;
   end
   assign mem_rdata = mem_active ? ({mem_addr[7:0], mem_addr[15:8]} ^ 16'h5A3C) : junk_r;
endmodule : zbi_mem_model

// >>> tb/zone_wait_hold_timing_tb_top.sv
// self-checking bench for the zone wait/hold timing block
`timescale 1ns/1ps
module zone_wait_hold_timing_tb_top;
   logic        clk_sys            = 1'b0;
   logic        rst_n              = 1'b0;
   logic        ce                 = 1'b1;
   logic        core_req           = 1'b0;
   logic        core_wr            = 1'b0;
   logic [15:0] core_addr          = 16'h0000;
   logic [15:0] core_wdata         = 16'h0000;
   logic        fast_eeprom_access = 1'b0;
   logic        core_done, mem_wr, mem_active, mem_hold, flash_bus_16, io_bus_16;
   logic [15:0] core_rdata, mem_rdata, mem_addr, mem_wdata;
   logic [2:0]  mem_zone;
   int          n_errors           = 0;
   int          samples_checked    = 0;
   logic [15:0] sh_fl              = 16'h069F;
   logic [15:0] sh_io              = 16'h069F;
   logic [15:0] sh_bu              = 16'h0007;
   // zone of the last completed access; 7 means not known yet after reset
   logic [2:0]  prev_z             = 3'h7;
   // edges with clock enable low inside the next access; zero for all but one
   int          n_frz              = 0;

   always #50 clk_sys = ~clk_sys;

   zbi_timing i_zbi_timing (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .core_req(core_req),
      .core_wr(core_wr), .core_addr(core_addr), .core_wdata(core_wdata),
      .core_done(core_done), .core_rdata(core_rdata),
      .fast_eeprom_access(fast_eeprom_access), .mem_rdata(mem_rdata), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_wr(mem_wr), .mem_zone(mem_zone), .mem_active(mem_active),
      .mem_hold(mem_hold), .flash_bus_16(flash_bus_16), .io_bus_16(io_bus_16));
   zbi_mem_model i_zbi_mem_model (.clk_sys(clk_sys), .mem_addr(mem_addr),
      .mem_active(mem_active), .mem_rdata(mem_rdata));

   // -----------------------------------------------------------------
   // expectations
   // -----------------------------------------------------------------
   function automatic logic [2:0] zone_of(input logic [15:0] a);
      if (a <= 16'hBFFF) return 3'h0;
      if (a >= 16'hE000 && a <= 16'hE7FF) return 3'h1;
      if (a >= 16'hF000 && a <= 16'hF27F) return 3'h2;
      if (a[15:8] == 8'hFB) return 3'h4;
      if (a >= 16'hF000) return 3'h3;
      return 3'h5;
   endfunction : zone_of

   function automatic int exp_lat(input logic wr, input logic [2:0] z, output int act,
                                  output int hld);
      int g, b, w, h;
      g = 0;
      b = 2;
      w = 1;
      h = 0;
      if (prev_z != z) begin
         if (prev_z == 3'h0) g += int'(sh_fl[9]);
         if (prev_z == 3'h4) g += int'(sh_io[9]);
         if (z == 3'h0) g += int'(sh_fl[10]);
      end
      case (z)
         3'h0: begin
            if (!wr && sh_fl[11]) begin
               b = 1;
               w = 0;
            end else begin
               w = 1 + (wr ? int'(sh_bu[0]) : 0) + (sh_fl[11] ? 0 : int'(sh_fl[2:0]));
               h = sh_fl[11] ? 0 : int'(sh_fl[4:3]);
            end
         end
         3'h1: w = 0;
         3'h2: w = fast_eeprom_access ? 0 : 1;
         3'h4: begin
            w = 1 + (wr ? int'(sh_bu[0]) : 0) + int'(sh_io[2:0]);
            h = int'(sh_io[4:3]);
         end
         default: w = 1;
      endcase
      act = b + w + h;
      hld = h;
      return g + b + w + h + 1;
   endfunction : exp_lat

   function automatic logic [15:0] rand_addr();
      logic [15:0] e [10] = '{16'hBFFF, 16'hC000, 16'hE000, 16'hE7FF, 16'hE800,
                              16'hF27F, 16'hF280, 16'hFB00, 16'hFBFE, 16'hFC00};
      logic [15:0] a;
      a = 16'($urandom);
      if ($urandom % 3 == 0) a = e[$urandom % 10];
      if (a[15:4] == 12'hF90) a[15:4] = 12'hF91;
      return a;
   endfunction : rand_addr

   // -----------------------------------------------------------------
   // checking and bus tasks
   // -----------------------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check

   task automatic access(input logic wr, input logic [15:0] a, input logic [15:0] d);
      int          cnt;
      int          el;
      int          ea;
      int          eh;
      int          n_act;
      int          n_hld;
      logic [2:0]  z;
      logic [15:0] er;
      z = zone_of(a);
      el = exp_lat(wr, z, ea, eh);
      er = (z == 3'h5) ? 16'h0000 : ({a[7:0], a[15:8]} ^ 16'h5A3C);
      if (a == zbi_pkg::ADDR_FLASH_CFG) er = sh_fl;
      if (a == zbi_pkg::ADDR_IO_ZONE_CFG) er = sh_io;
      if (a == zbi_pkg::ADDR_BUS_UNIT_CFG) er = sh_bu;
      @(posedge clk_sys);
      core_req <= 1'b1;
      core_wr <= wr;
      core_addr <= a;
      core_wdata <= d;
      cnt = 0;
      n_act = 0;
      n_hld = 0;
      do begin
         @(posedge clk_sys);
         // frozen edges must stretch the access by exactly their number
         ce <= !(cnt >= 1 && cnt <= n_frz);
         #1;
         cnt++;
         n_act += int'(mem_active === 1'b1);
         n_hld += int'(mem_hold === 1'b1);
      end while (core_done !== 1'b1 && cnt < 40);
      check({15'h0, core_done}, 16'h0001, "completion");
      if (prev_z != 3'h7) check(16'(cnt), 16'(el + n_frz), "latency");
      check(16'(n_act), 16'(ea + n_frz), "active cycles");
      check(16'(n_hld), 16'(eh), "hold cycles");
      check({15'h0, mem_wr}, {15'h0, wr}, "direction");
      if (wr) check(mem_wdata, d, "write data");
      check({13'h0, mem_zone}, {13'h0, z}, "zone");
      check(mem_addr, a, "address");
      if (!wr) check(core_rdata, er, "read data");
      @(posedge clk_sys);
      core_req <= 1'b0;
      if (wr && a == zbi_pkg::ADDR_FLASH_CFG)
         sh_fl = (sh_fl & ~zbi_pkg::MSK_FLASH_CFG) | (d & zbi_pkg::MSK_FLASH_CFG);
      if (wr && a == zbi_pkg::ADDR_IO_ZONE_CFG)
         sh_io = (sh_io & ~zbi_pkg::MSK_IO_ZONE_CFG) | (d & zbi_pkg::MSK_IO_ZONE_CFG);
      if (wr && a == zbi_pkg::ADDR_BUS_UNIT_CFG)
         sh_bu = (sh_bu & ~zbi_pkg::MSK_BUS_UNIT_CFG) | (d & zbi_pkg::MSK_BUS_UNIT_CFG);
      prev_z = z;
   endtask : access

   task automatic finish_test();
      $display("checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : finish_test

   // -----------------------------------------------------------------
   // main sequence
   // -----------------------------------------------------------------
   initial begin
      logic [15:0] fl_c [4] = '{16'h0E80, 16'h0680, 16'h069F, 16'h0418};
      logic [15:0] io_c [4] = '{16'h0288, 16'h029F, 16'h0000, 16'h0207};
      logic [15:0] fl, io;
      void'($urandom(32'h1f3d));
      repeat (3) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
      check({15'h0, flash_bus_16}, 16'h0001, "flash width at reset");
      check({15'h0, io_bus_16}, 16'h0001, "io width at reset");
      access(1'b0, zbi_pkg::ADDR_FLASH_CFG, 16'h0000);
      access(1'b0, zbi_pkg::ADDR_IO_ZONE_CFG, 16'h0000);
      access(1'b0, zbi_pkg::ADDR_BUS_UNIT_CFG, 16'h0000);
      $display("test reset_values done");
      n_frz = 3;
      access(1'b0, 16'h0100, 16'h0000);
      n_frz = 0;
      $display("test clock_enable done");
      for (int k = 0; k < 10; k++) begin
         fl = (k < 4) ? fl_c[k] : 16'($urandom);
         io = (k < 4) ? io_c[k] : 16'($urandom);
         access(1'b1, zbi_pkg::ADDR_FLASH_CFG, fl & ~16'h0060);
         access(1'b1, zbi_pkg::ADDR_IO_ZONE_CFG, io);
         access(1'b1, zbi_pkg::ADDR_BUS_UNIT_CFG, 16'h0006 | 16'(k % 2));
         fast_eeprom_access <= ($urandom % 2 == 1);
         access(1'b0, zbi_pkg::ADDR_FLASH_CFG, 16'h0000);
         check({15'h0, flash_bus_16}, {15'h0, sh_fl[7]}, "flash width");
         check({15'h0, io_bus_16}, {15'h0, sh_io[7]}, "io width");
         repeat (30) access(1'($urandom % 2), rand_addr(), 16'($urandom));
         $display("test config_%0d done", k);
      end
      finish_test();
   end

   initial begin
      #(100 * 60000);
      n_errors++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      finish_test();
   end
endmodule : zone_wait_hold_timing_tb_top
